// *** logic/ibl_regs.vh ***
// Purpose: Constants for the in-band loop-code generator and detector
// Assumes: 125 MHz system clock; registers reached over APB, one word each
// Notes: A register index times four is its byte address
`ifndef IBL_REGS_VH
`define IBL_REGS_VH

// Register indexes
`define IBL_IDX_CODE_CTRL 6'h0a
`define IBL_IDX_TX_LOW 6'h0b
`define IBL_IDX_TX_HIGH 6'h0c
`define IBL_IDX_UP_LOW 6'h0d
`define IBL_IDX_UP_HIGH 6'h0e
`define IBL_IDX_DN_LOW 6'h0f
`define IBL_IDX_DN_HIGH 6'h10
`define IBL_IDX_STATUS 6'h11
`define IBL_IDX_LOOP_CTRL 6'h12

// Field positions
`define IBL_TX_LEN_MSB 7
`define IBL_TX_LEN_LSB 6
`define IBL_UP_LEN_MSB 5
`define IBL_UP_LEN_LSB 3
`define IBL_DN_LEN_MSB 2
`define IBL_DN_LEN_LSB 0
`define IBL_ST_UP_BIT 7
`define IBL_ST_DN_BIT 6
`define IBL_ST_REMOTE_BIT 0
`define IBL_CTL_AUTO_RLB_BIT 5
`define IBL_CTL_TX_EN_BIT 3

// Transmit length codes
`define IBL_TXLEN_5 2'h0
`define IBL_TXLEN_6 2'h1
`define IBL_TXLEN_7 2'h2

// Reset value of every writable register
`define IBL_RESET_BYTE 8'h00

// Timing
`define IBL_CLK_MHZ 125
`define IBL_INTEG_MS 48
`define IBL_INTEG_CYCLES (`IBL_INTEG_MS * `IBL_CLK_MHZ * 1000)
`define IBL_HOLD_S 5
`define IBL_HOLD_CYCLES (`IBL_HOLD_S * `IBL_CLK_MHZ * 1000000)

// Error tolerance: at most this many bit errors in each 128-bit window
`define IBL_ERR_MAX 4'h8

`endif

// *** logic/ibl_loop_code.v ***
// Purpose: In-band loop-code generator and dual loop-up/loop-down detector
// Assumes: Line bit strobes are synchronous one-cycle pulses on clock_i
// Notes: Registers over APB with one wait state; data in the low byte
// Contract
// - Generate repeating patterns of 5 to 7 or 16 bits; detect patterns of 1 to 7 or 16 bits.
// - Transmit length code: 00 five, 01 six, 10 seven, 11 sixteen bits.
// - Pattern is sent continuously while transmit enable is set, stops when cleared.
// - Low-byte bit 7 is sent first, then lower bits in descending order.
// - Low-byte bits beyond the selected transmit length are ignored.
// - High transmit byte supplies pattern bits 15 to 8 for 16-bit codes.
// - Two independent detectors run together: loop-up and loop-down.
// - Receive length codes 000-110 give 1-7 bits, 111 gives 16 bits.
// - Control byte: transmit length 7:6, up length 5:3, down length 2:0.
// - Detectors keep a match at bit-error rates up to one in a hundred.
// - After 48 ms of matching code set status bit 7 or bit 6.
// - Up detector takes bit 7 first and ignores bits beyond its length.
// - Down detector takes bit 7 first and ignores bits beyond its length.
// - High up byte supplies pattern bits 15 to 8 for 16-bit length.
// - High down byte supplies pattern bits 15 to 8 for 16-bit length.
// - Auto loopback: enter after 5 s loop-up, leave after 5 s loop-down.
//
// Design decision made here: the APB slave port.
`include "ibl_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module ibl_loop_code
#(
   parameter INTEG_CYCLES = `IBL_INTEG_CYCLES,
   parameter HOLD_CYCLES = `IBL_HOLD_CYCLES
)
(
   // Clock and reset
   input wire clock_i,
   input wire rst_i,
   // APB slave
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   output reg [31:0] prdata_o,
   output reg pready_o,
   output reg pslverr_o,
   // Transmit bit stream
   input wire tx_bit_req_i,
   input wire tx_data_i,
   output reg tx_bit_o,
   output reg tx_bit_valid_o,
   // Receive bit stream
   input wire rx_bit_valid_i,
   input wire rx_bit_i,
   // Status
   output wire loop_up_detected_o,
   output wire loop_down_detected_o,
   output reg remote_loop_o
);

   localparam [31:0] INTEG_LAST = INTEG_CYCLES - 1;
   localparam [31:0] HOLD_LAST = HOLD_CYCLES - 1;

   // Pattern bit for phase: C7..C0 first, then C15..C8
   function pat_bit;
      input [15:0] pat;
      input [3:0] ph;
      begin
         pat_bit = pat[{ph[3], ~ph[2:0]}];
      end
   endfunction

   function [4:0] rx_len;
      input [2:0] code;
      begin
         if (code == 3'h7)
            rx_len = 5'h10;
         else
            rx_len = {2'h0, code} + 5'h01;
      end
   endfunction

   function [4:0] tx_len;
      input [1:0] code;
      begin
         case (code)
            `IBL_TXLEN_5: tx_len = 5'h05;
            `IBL_TXLEN_6: tx_len = 5'h06;
            `IBL_TXLEN_7: tx_len = 5'h07;
            default: tx_len = 5'h10;
         endcase
      end
   endfunction

   // Newest bit in hist[0]; the oldest of len bits must equal C7
   function win_match;
      input [15:0] hist;
      input [15:0] pat;
      input [4:0] len;
      integer k;
      reg [4:0] idx;
      begin
         win_match = 1'b1;
         for (k = 0; k < 16; k = k + 1)
         begin
            idx = len - 5'h01 - k[4:0];
            if ((k[4:0] < len) && (hist[idx[3:0]] != pat_bit(pat, k[3:0])))
               win_match = 1'b0;
         end
      end
   endfunction

   // Registers
   reg [7:0] code_control_reg;
   reg [7:0] tx_pattern_low;
   reg [7:0] tx_pattern_high;
   reg [7:0] up_pattern_low;
   reg [7:0] up_pattern_high;
   reg [7:0] down_pattern_low;
   reg [7:0] down_pattern_high;
   reg [7:0] loop_ctrl;
   reg [7:0] rd_byte;
   reg mapped;

   wire [5:0] idx = paddr_i[7:2];
   wire access = psel_i & penable_i;
   wire do_write = access & pready_o & pwrite_i & mapped;
   wire [1:0] det_flag;
   wire tx_en = loop_ctrl[`IBL_CTL_TX_EN_BIT];
   wire auto_rlb = loop_ctrl[`IBL_CTL_AUTO_RLB_BIT];
   wire [7:0] status_reg;

   assign status_reg = {det_flag[0], det_flag[1], 5'h00, remote_loop_o};
   assign loop_up_detected_o = det_flag[0];
   assign loop_down_detected_o = det_flag[1];

   always @*
   begin
      mapped = (paddr_i[1:0] == 2'h0);
      case (idx)
         `IBL_IDX_CODE_CTRL: rd_byte = code_control_reg;
         `IBL_IDX_TX_LOW: rd_byte = tx_pattern_low;
         `IBL_IDX_TX_HIGH: rd_byte = tx_pattern_high;
         `IBL_IDX_UP_LOW: rd_byte = up_pattern_low;
         `IBL_IDX_UP_HIGH: rd_byte = up_pattern_high;
         `IBL_IDX_DN_LOW: rd_byte = down_pattern_low;
         `IBL_IDX_DN_HIGH: rd_byte = down_pattern_high;
         `IBL_IDX_STATUS: rd_byte = status_reg;
         `IBL_IDX_LOOP_CTRL: rd_byte = loop_ctrl;
         default:
         begin
            rd_byte = 8'h00;
            mapped = 1'b0;
         end
      endcase
   end

   // One wait state: answer is registered on the first access edge
   always @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         prdata_o <= 32'h00000000;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end
      else if (access && !pready_o)
      begin
         prdata_o <= {24'h000000, rd_byte};
         pready_o <= 1'b1;
         pslverr_o <= ~mapped;
      end
      else
      begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end
   end

   // Status register is read-only; writes to it are dropped
   always @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         code_control_reg <= `IBL_RESET_BYTE;
         tx_pattern_low <= `IBL_RESET_BYTE;
         tx_pattern_high <= `IBL_RESET_BYTE;
         up_pattern_low <= `IBL_RESET_BYTE;
         up_pattern_high <= `IBL_RESET_BYTE;
         down_pattern_low <= `IBL_RESET_BYTE;
         down_pattern_high <= `IBL_RESET_BYTE;
         loop_ctrl <= `IBL_RESET_BYTE;
      end
      else if (do_write)
      begin
         case (idx)
            `IBL_IDX_CODE_CTRL: code_control_reg <= pwdata_i[7:0];
            `IBL_IDX_TX_LOW: tx_pattern_low <= pwdata_i[7:0];
            `IBL_IDX_TX_HIGH: tx_pattern_high <= pwdata_i[7:0];
            `IBL_IDX_UP_LOW: up_pattern_low <= pwdata_i[7:0];
            `IBL_IDX_UP_HIGH: up_pattern_high <= pwdata_i[7:0];
            `IBL_IDX_DN_LOW: down_pattern_low <= pwdata_i[7:0];
            `IBL_IDX_DN_HIGH: down_pattern_high <= pwdata_i[7:0];
            `IBL_IDX_LOOP_CTRL: loop_ctrl <= pwdata_i[7:0];
            default: loop_ctrl <= loop_ctrl;
         endcase
      end
   end

   // Transmitter
   reg [3:0] tx_phase;
   wire [15:0] tx_pat = {tx_pattern_high, tx_pattern_low};
   wire [4:0] tx_l = tx_len(code_control_reg[`IBL_TX_LEN_MSB:`IBL_TX_LEN_LSB]);

   always @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         tx_phase <= 4'h0;
         tx_bit_o <= 1'b0;
         tx_bit_valid_o <= 1'b0;
      end
      else
      begin
         tx_bit_valid_o <= tx_bit_req_i;
         if (!tx_en)
            tx_phase <= 4'h0;
         if (tx_bit_req_i)
         begin
            if (tx_en)
            begin
               tx_bit_o <= pat_bit(tx_pat, tx_phase);
               // A shortened length mid-code wraps at once
               if ({1'b0, tx_phase} >= tx_l - 5'h01)
                  tx_phase <= 4'h0;
               else
                  tx_phase <= tx_phase + 4'h1;
            end
            else
            begin
               tx_bit_o <= tx_data_i;
            end
         end
      end
   end

   // Detectors: 0 is loop-up, 1 is loop-down
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : det
         wire [15:0] pat;
         wire [2:0] len_code;
         wire [4:0] len;
         reg [15:0] hist;
         reg [18:0] cfg_q;
         reg locked;
         reg [3:0] phase;
         reg [6:0] win_cnt;
         reg [3:0] err_cnt;
         reg [31:0] integ;
         reg det_q;
         wire miss;
         wire [15:0] next_hist = {hist[14:0], rx_bit_i};

         if (g == 0)
         begin : up
            assign pat = {up_pattern_high, up_pattern_low};
            assign len_code = code_control_reg[`IBL_UP_LEN_MSB:`IBL_UP_LEN_LSB];
         end
         else
         begin : dn
            assign pat = {down_pattern_high, down_pattern_low};
            assign len_code = code_control_reg[`IBL_DN_LEN_MSB:`IBL_DN_LEN_LSB];
         end

         assign len = rx_len(len_code);
         assign miss = (rx_bit_i != pat_bit(pat, phase));
         assign det_flag[g] = det_q;

         always @(posedge clock_i or posedge rst_i)
         begin
            if (rst_i)
            begin
               hist <= 16'h0000;
               cfg_q <= 19'h00000;
               locked <= 1'b0;
               phase <= 4'h0;
               win_cnt <= 7'h00;
               err_cnt <= 4'h0;
               integ <= 32'h00000000;
               det_q <= 1'b0;
            end
            else
            begin
               cfg_q <= {pat, len_code};
               if (rx_bit_valid_i)
                  hist <= next_hist;
               // A new code or length restarts the search
               if (cfg_q != {pat, len_code})
               begin
                  locked <= 1'b0;
                  integ <= 32'h00000000;
                  det_q <= 1'b0;
               end
               else if (!locked)
               begin
                  integ <= 32'h00000000;
                  det_q <= 1'b0;
                  if (rx_bit_valid_i && win_match(next_hist, pat, len))
                  begin
                     locked <= 1'b1;
                     phase <= 4'h0;
                     win_cnt <= 7'h00;
                     err_cnt <= 4'h0;
                  end
               end
               else
               begin
                  if (integ == INTEG_LAST)
                     det_q <= 1'b1;
                  else
                     integ <= integ + 32'h00000001;
                  if (rx_bit_valid_i)
                  begin
                     if ({1'b0, phase} == len - 5'h01)
                        phase <= 4'h0;
                     else
                        phase <= phase + 4'h1;
                     win_cnt <= win_cnt + 7'h01;
                     // Tolerate sparse errors; a burst drops the lock
                     if (miss && (err_cnt == `IBL_ERR_MAX))
                        locked <= 1'b0;
                     else if (win_cnt == 7'h7f)
                        err_cnt <= {3'h0, miss};
                     else if (miss)
                        err_cnt <= err_cnt + 4'h1;
                  end
               end
            end
         end
      end
   endgenerate

   // Automatic remote loopback, timed from the detection flags
   reg [31:0] hold_cnt;
   wire hold_src = remote_loop_o ? det_flag[1] : det_flag[0];

   always @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         hold_cnt <= 32'h00000000;
         remote_loop_o <= 1'b0;
      end
      else if (!auto_rlb)
      begin
         hold_cnt <= 32'h00000000;
         remote_loop_o <= 1'b0;
      end
      else if (!hold_src)
      begin
         hold_cnt <= 32'h00000000;
      end
      else if (hold_cnt == HOLD_LAST)
      begin
         hold_cnt <= 32'h00000000;
         remote_loop_o <= ~remote_loop_o;
      end
      else
      begin
         hold_cnt <= hold_cnt + 32'h00000001;
      end
   end

endmodule // ibl_loop_code

`default_nettype wire

// *** sim/ibl_line_partner.sv ***
// Purpose: Far-end line equipment sending a repeating loop code
// Assumes: One bit per strobe, strobes spaced by gap_i idle cycles
// Notes: err_i flips one bit in every hundred sent
`timescale 1ns/1ps
`default_nettype none
module ibl_line_partner
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Stream control
   input wire logic on_i,
   input wire logic err_i,
   input wire logic [15:0] code_i,
   input wire logic [4:0] len_i,
   input wire logic [3:0] gap_i,
   // Line bits
   output logic rx_bit_valid_o,
   output logic rx_bit_o
);
   logic [3:0] idle;
   logic [4:0] ph;
   logic [6:0] nb;
   always @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         idle <= 4'h0;
         ph <= 5'h00;
         nb <= 7'h00;
         rx_bit_valid_o <= 1'b0;
         rx_bit_o <= 1'b0;
      end
      else if (on_i && idle >= gap_i)
      begin
         idle <= 4'h0;
         rx_bit_valid_o <= 1'b1;
         rx_bit_o <= code_i[ph < 5'h08 ? 5'h07 - ph : 5'h17 - ph] ^ (err_i && nb == 7'h63);
         ph <= (ph + 5'h01 >= len_i) ? 5'h00 : ph + 5'h01;
         nb <= (nb == 7'h63) ? 7'h00 : nb + 7'h01;
      end
      else
      begin
         idle <= idle + 4'h1;
         rx_bit_valid_o <= 1'b0;
         // Stale data between strobes must never look valid
         rx_bit_o <= ~rx_bit_o;
      end
   end
endmodule // ibl_line_partner
`default_nettype wire

// *** sim/ibl_loop_code_monitor.sv ***
// Purpose: Port checker for the loop-code block
// Assumes: One clock domain, asynchronous active-high reset
// Notes: Flag timing is judged from the block's own count parameters
`timescale 1ns/1ps
`default_nettype none
module ibl_loop_code_monitor
#(
   parameter INTEG_CYCLES = 200,
   parameter HOLD_CYCLES = 500
)
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // APB
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // Streams and status
   input wire logic tx_bit_req_i,
   input wire logic tx_data_i,
   input wire logic tx_bit_o,
   input wire logic tx_bit_valid_o,
   input wire logic rx_bit_valid_i,
   input wire logic rx_bit_i,
   input wire logic loop_up_detected_o,
   input wire logic loop_down_detected_o,
   input wire logic remote_loop_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   wire logic ap = psel_i && penable_i && !pready_o;
   int up_low, dn_low, up_run;
   always @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         up_low <= 0;
         dn_low <= 0;
         up_run <= 0;
      end
      else
      begin
         up_low <= loop_up_detected_o ? 0 : up_low + 1;
         dn_low <= loop_down_detected_o ? 0 : dn_low + 1;
         up_run <= loop_up_detected_o ? up_run + 1 : 0;
      end
   end
   AST_ACCESS_ANSWER: assert property (ap |=> pready_o)
      else $error("access not answered");
   AST_MISALIGN_REFUSED: assert property (ap && paddr_i[1:0] != 2'h0 |=> pslverr_o)
      else $error("misaligned access accepted");
   AST_DATA_BYTE: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
      else $error("read data above the byte");
   AST_TX_ANSWER: assert property (tx_bit_req_i |=> tx_bit_valid_o)
      else $error("transmit request unanswered");
   AST_TX_HOLD: assert property (!tx_bit_req_i |=> $stable(tx_bit_o))
      else $error("transmit bit moved without request");
   AST_UP_INTEGRATES: assert property ($rose(loop_up_detected_o) |-> up_low >= INTEG_CYCLES - 4)
      else $error("loop-up flag set too early");
   AST_DN_INTEGRATES: assert property ($rose(loop_down_detected_o) |-> dn_low >= INTEG_CYCLES - 4)
      else $error("loop-down flag set too early");
   AST_REMOTE_AFTER_HOLD: assert property ($rose(remote_loop_o) |-> up_run >= HOLD_CYCLES - 2)
      else $error("remote loop entered too early");
   AST_STATUS_READ: assert property (ap && !pwrite_i && paddr_i == 8'h44 ##1 ($stable(loop_up_detected_o)
      && $stable(loop_down_detected_o)) |-> prdata_o[7:6] == {loop_up_detected_o, loop_down_detected_o})
      else $error("status read disagrees with flags");
   cover property ($rose(loop_up_detected_o));
   cover property ($rose(loop_down_detected_o));
   cover property ($fell(remote_loop_o));
endmodule // ibl_loop_code_monitor
bind ibl_loop_code ibl_loop_code_monitor #(.INTEG_CYCLES(INTEG_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)) u_mon (
   .clock_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
   .pslverr_o, .tx_bit_req_i, .tx_data_i, .tx_bit_o, .tx_bit_valid_o, .rx_bit_valid_i, .rx_bit_i,
   .loop_up_detected_o, .loop_down_detected_o, .remote_loop_o);
`default_nettype wire

// *** sim/inband_loop_code_gen_detect_test.sv ***
// Purpose: Self-checking bench for the loop-code block
// Assumes: Integration and hold counts shortened to 200 and 500 clocks
// Notes: Expectations come from a register model and the code tables
`timescale 1ns/1ps
`default_nettype none
module inband_loop_code_gen_detect_test;
   logic clock_i = 1'b0, rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic req = 1'b0, txd = 1'b0, on = 1'b0, err = 1'b0, e;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h9d34;
   logic pready, pslverr, txb, txv, rxv, rxb, up, dn, rl;
   logic [15:0] code = 16'h0;
   logic [4:0] len = 5'h1;
   logic [3:0] gap = 4'h0;
   logic [7:0] mdl [0:18];
   logic q [$];
   int mismatches = 0, n_tests = 0, i, k, n, nl;
   ibl_loop_code #(.INTEG_CYCLES(200), .HOLD_CYCLES(500)) DUT (.clock_i, .rst_i,
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .tx_bit_req_i(req),
      .tx_data_i(txd), .tx_bit_o(txb), .tx_bit_valid_o(txv), .rx_bit_valid_i(rxv),
      .rx_bit_i(rxb), .loop_up_detected_o(up), .loop_down_detected_o(dn), .remote_loop_o(rl));
   ibl_line_partner u_far (.clock_i, .rst_i, .on_i(on), .err_i(err), .code_i(code),
      .len_i(len), .gap_i(gap), .rx_bit_valid_o(rxv), .rx_bit_o(rxb));
   initial forever #4 clock_i = ~clock_i;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic sig(input int w);
      return w == 0 ? up : (w == 1 ? dn : rl);
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the answer
      do
      begin
         @(posedge clock_i);
      end
      while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      logic ok;
      ok = a[1:0] == 2'h0 && a[7:2] >= 6'h0a && a[7:2] <= 6'h12;
      apb(w, a, d);
      if (w && ok && a[7:2] != 6'h11)
         mdl[a[7:2]] = d[7:0];
      if (!w)
         chk(rd, ok ? {24'h0, mdl[a[7:2]]} : 32'h0);
      chk({31'h0, e}, {31'h0, !ok});
   endtask
   task pulse;
      @(posedge clock_i);
      req <= 1'b1;
      txd <= ~txd;
      @(posedge clock_i);
      req <= 1'b0;
      @(posedge clock_i);
   endtask
   task wt(input int w, input logic v);
      n = 0;
      while (sig(w) !== v && n < 3000)
      begin
         @(posedge clock_i);
         n++;
      end
      chk({31'h0, sig(w)}, {31'h0, v});
   endtask
   task wrap_up;
      $display("compares %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      for (i = 0; i < 19; i++)
         mdl[i] = 8'h00;
      repeat (8) @(posedge clock_i);
      rst_i <= 1'b0;
      for (i = 8'h28; i <= 8'h48; i += 4)
         acc(1'b0, i[7:0], 32'h0);
      acc(1'b0, 8'h80, 32'h0);
      acc(1'b1, 8'h29, 32'h5);
      acc(1'b1, 8'h44, 32'hff);
      acc(1'b0, 8'h44, 32'h0);
      for (i = 8'h28; i <= 8'h48; i += 4)
      begin
         seed = lfsr(seed);
         acc(1'b1, i[7:0], seed);
         acc(1'b0, i[7:0], 32'h0);
      end
      for (k = 0; k < 4; k++)
      begin
         seed = lfsr(seed);
         nl = k == 3 ? 16 : k + 5;
         acc(1'b1, 8'h28, {24'h0, k[1:0], 6'h0});
         acc(1'b1, 8'h2c, seed);
         acc(1'b1, 8'h30, seed >> 8);
         acc(1'b1, 8'h48, 32'h8);
         for (i = 0; i < 2 * nl; i++)
            q.push_back(i % nl < 8 ? mdl[11][7 - i % nl] : mdl[12][15 - i % nl]);
         while (q.size() > 0)
         begin
            pulse();
            chk({txv, txb}, {1'b1, q.pop_front()});
         end
         acc(1'b1, 8'h48, 32'h0);
         pulse();
         chk({txv, txb}, {1'b1, txd});
      end
      err <= 1'b1;
      for (k = 0; k < 8; k++)
      begin
         on <= 1'b0;
         seed = lfsr(seed);
         acc(1'b1, 8'h28, {26'h0, k[2:0], 3'h7});
         acc(1'b1, 8'h34, seed);
         acc(1'b1, 8'h38, seed >> 8);
         code <= {mdl[14], mdl[13]};
         len <= k == 7 ? 5'd16 : k[4:0] + 5'd1;
         gap <= {2'h0, k[1:0]};
         on <= 1'b1;
         repeat (20) @(posedge clock_i);
         chk({31'h0, up}, 32'h0);
         wt(0, 1'b1);
         mdl[17] = 8'h80;
         acc(1'b0, 8'h44, 32'h0);
      end
      acc(1'b1, 8'h28, 32'h27);
      acc(1'b1, 8'h34, 32'h80);
      acc(1'b1, 8'h3c, 32'h5a);
      acc(1'b1, 8'h40, 32'hc3);
      acc(1'b1, 8'h48, 32'h20);
      code <= 16'h0080;
      len <= 5'd5;
      wt(0, 1'b1);
      chk({31'h0, dn}, 32'h0);
      wt(2, 1'b1);
      mdl[17] = 8'h81;
      acc(1'b0, 8'h44, 32'h0);
      code <= 16'hc35a;
      len <= 5'd16;
      wt(1, 1'b1);
      wt(2, 1'b0);
      mdl[17] = 8'h40;
      acc(1'b0, 8'h44, 32'h0);
      wrap_up;
   end
   // Several times the expected run, so only a hang reaches it
   initial
   begin
      repeat (60000) @(posedge clock_i);
      mismatches++;
      wrap_up;
   end
endmodule // inband_loop_code_gen_detect_test
`default_nettype wire
